/* logic/zero_hold_pkg.sv */
// package: register map, field limits, state and struct types for zero-speed hold
package zero_hold_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// wishbone register word addresses (byte address bits 7:2)
	localparam logic [5:0] ADR_ZERO_SPEED_LEVEL = 6'h00;
	localparam logic [5:0] ADR_MIN_OUTPUT_FREQ = 6'h01;
	localparam logic [5:0] ADR_HOLD_GAIN = 6'h02;
	localparam logic [5:0] ADR_HOLD_WIDTH = 6'h03;
	localparam logic [5:0] ADR_SPEED_REF = 6'h04;
	localparam logic [5:0] ADR_STATUS = 6'h05;
	localparam logic [5:0] ADR_POSITION = 6'h06;
	localparam logic [5:0] ADR_CAPTURED = 6'h07;
	localparam logic [5:0] ADR_DEVIATION = 6'h08;
	localparam logic [5:0] ADR_IN_SEL_BASE = 6'h10;
	localparam logic [5:0] ADR_OUT_SEL_BASE = 6'h20;

	////////////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int N_INPUTS = 10;
	localparam int N_OUTPUTS = 3;
	localparam int POS_W = 32;
	localparam int CORR_W = 16;

	////////////////////////////////////////////////////////////////////////////////
	// selector codes
	localparam logic [7:0] SEL_HOLD_COMMAND = 8'h48;
	localparam logic [7:0] SEL_HOLD_DONE = 8'h21;

	////////////////////////////////////////////////////////////////////////////////
	// setting limits and reset values (frequencies in 0.1 hz)
	localparam logic [31:0] ZSL_MAX = 32'h0000_0064;
	localparam logic [6:0] ZSL_RST = 7'h05;
	localparam logic [15:0] MINF_RST = 16'h0000;
	localparam logic [31:0] GAIN_MAX = 32'h0000_0064;
	localparam logic [6:0] GAIN_RST = 7'h05;
	localparam logic [31:0] WIDTH_MAX = 32'h0000_3fff;
	localparam logic [13:0] WIDTH_RST = 14'h000a;

	////////////////////////////////////////////////////////////////////////////////
	// status bits
	localparam int ST_HOLD = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ENABLED = 2;
	localparam int ST_RUN = 3;
	localparam int ST_CMD = 4;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [0:0] {HOLD_IDLE, HOLD_LOCKED} hold_e;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] prev;
		logic signed [POS_W-1:0] pos;
	} qdec_s;

	typedef struct packed {
		logic [N_INPUTS:0] pin_s1;
		logic [N_INPUTS:0] pin_s2;
		logic [6:0] zsl;
		logic [15:0] minf;
		logic [6:0] gain;
		logic [13:0] width;
		logic signed [15:0] speed_ref;
		logic [N_INPUTS-1:0][7:0] in_sel;
		logic [N_OUTPUTS-1:0][7:0] out_sel;
		hold_e st;
		logic signed [POS_W-1:0] cap;
		logic hold_done;
		logic [N_OUTPUTS-1:0] mf_out;
		logic signed [CORR_W-1:0] corr;
		logic ack;
		logic [31:0] dat;
	} core_s;

endpackage

/* logic/quad_counter.sv */
// quadrature decoder: synchronised phases into a signed edge counter
`timescale 1ns/1ps
module quad_counter
	import zero_hold_pkg::*;
(
	// clock and control
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// encoder phases from pins
	input wire logic i_phase_a,
	input wire logic i_phase_b,
	// position in quadrature counts
	output logic signed [POS_W-1:0] o_position
);

	qdec_s q_q;
	qdec_s q_d;

	////////////////////////////////////////////////////////////////////////////////
	// every edge of either phase counts once; both phases changing in the same sample count nothing
	always_comb begin
		q_d = q_q;
		q_d.s1 = {i_phase_a, i_phase_b};
		q_d.s2 = q_q.s1;
		q_d.prev = q_q.s2;
		if ((q_q.s2 != q_q.prev) && ((q_q.s2 ^ q_q.prev) != 2'h3)) begin
			if (q_q.s2[1] ^ q_q.prev[0]) begin
				q_d.pos = q_q.pos + 32'sh1;
			end else begin
				q_d.pos = q_q.pos - 32'sh1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			q_q <= '0;
		end else if (i_ce) begin
			q_q <= q_d;
		end
	end

	assign o_position = q_q.pos;

endmodule

/* logic/zero_speed_position_hold.sv */
// zero-speed position hold with wishbone settings and quadrature position loop
//
// How it works
// - hold enabled only if an input selects 72
// - enter hold on command below zero speed
// - zero speed level 0.0..10.0 hz, default 0.5
// - minimum output frequency floors the threshold
// - capture position and close position loop
// - hold gain 0..100, default 5, proportional
// - completion while within capture plus minus width
// - completion width 0..16383, default 10
// - width compared in quadrature counts
// - hold ignores speed reference and shaft force
// - completion drops when command drops
// - output selector 33 routes completion status
`timescale 1ns/1ps
module zero_speed_position_hold
	import zero_hold_pkg::*;
(
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// drive control pins
	input wire logic [N_INPUTS-1:0] i_mf_in,
	input wire logic i_run,
	// shaft encoder pins
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	// hold results
	output logic [N_OUTPUTS-1:0] o_mf_out,
	output logic o_hold_active,
	output logic o_hold_done,
	output logic signed [CORR_W-1:0] o_speed_corr
);

	////////////////////////////////////////////////////////////////////////////////
	// local limits

	localparam int ADR_LSB = 2;
	localparam int ADR_MSB = 7;
	localparam logic signed [POS_W+8:0] CORR_HI = 41'sh0_0000_7fff;
	localparam logic signed [POS_W+8:0] CORR_LO = -41'sh0_0000_8000;
	localparam logic signed [CORR_W-1:0] CORR_SAT_HI = 16'sh7fff;
	localparam logic signed [CORR_W-1:0] CORR_SAT_LO = 16'sh8000;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] clamp_max(input logic [31:0] v, input logic [31:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	function automatic logic [POS_W-1:0] abs_pos(input logic signed [POS_W-1:0] v);
		return v[POS_W-1] ? 32'(-v) : 32'(v);
	endfunction

	function automatic logic [15:0] abs_ref(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	function automatic logic in_sel_hit(input logic [5:0] a);
		return (a >= ADR_IN_SEL_BASE) && (a < ADR_IN_SEL_BASE + 6'(N_INPUTS));
	endfunction

	function automatic logic out_sel_hit(input logic [5:0] a);
		return (a >= ADR_OUT_SEL_BASE) && (a < ADR_OUT_SEL_BASE + 6'(N_OUTPUTS));
	endfunction

	function automatic logic read_only(input logic [5:0] a);
		return (a == ADR_STATUS) || (a == ADR_POSITION) || (a == ADR_CAPTURED)
			|| (a == ADR_DEVIATION);
	endfunction

	function automatic logic signed [CORR_W-1:0] sat_corr(input logic signed [POS_W+8:0] v);
		logic signed [CORR_W-1:0] r;
		if (v > CORR_HI) begin
			r = CORR_SAT_HI;
		end else if (v < CORR_LO) begin
			r = CORR_SAT_LO;
		end else begin
			r = v[CORR_W-1:0];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state and decoded terms

	core_s q_q;
	core_s q_d;
	logic signed [POS_W-1:0] position;
	logic [N_INPUTS-1:0] cmd_sel_mask;
	logic hold_enabled;
	logic hold_request;
	logic locked;
	logic in_window;
	logic [N_OUTPUTS-1:0] done_sel_mask;
	logic hold_cmd;
	logic run_on;
	logic [15:0] thr_eff;
	logic [15:0] ref_mag;
	logic below_zero_speed;
	logic signed [POS_W-1:0] deviation;
	logic signed [POS_W+8:0] corr_full;
	logic wb_req;
	logic [5:0] wadr;
	logic [31:0] wr_old;
	logic [31:0] wr_val;
	logic [31:0] rd_val;

	quad_counter u_quad (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_phase_a(i_enc_a),
		.i_phase_b(i_enc_b),
		.o_position(position)
	);

	////////////////////////////////////////////////////////////////////////////////
	// selector decode per input

	genvar gi;
	generate
		for (gi = 0; gi < N_INPUTS; gi++) begin : g_sel
			assign cmd_sel_mask[gi] = (q_q.in_sel[gi] == SEL_HOLD_COMMAND);
		end
	endgenerate

	assign hold_enabled = |cmd_sel_mask;
	assign hold_cmd = |(cmd_sel_mask & q_q.pin_s2[N_INPUTS-1:0]);
	assign run_on = q_q.pin_s2[N_INPUTS];
	assign hold_request = hold_enabled && hold_cmd && run_on;
	assign locked = (q_q.st == HOLD_LOCKED);

	generate
		for (gi = 0; gi < N_OUTPUTS; gi++) begin : g_out
			assign done_sel_mask[gi] = (q_q.out_sel[gi] == SEL_HOLD_DONE);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// threshold and loop arithmetic

	assign thr_eff = ({9'h000, q_q.zsl} < q_q.minf) ? q_q.minf : {9'h000, q_q.zsl};
	assign ref_mag = abs_ref(q_q.speed_ref);
	assign below_zero_speed = (ref_mag < thr_eff);
	assign deviation = position - q_q.cap;
	assign corr_full = -(41'(deviation) * 41'($signed({1'b0, q_q.gain})));
	assign in_window = (abs_pos(deviation) <= {18'h0, q_q.width});

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	assign wb_req = i_wb_cyc && i_wb_stb && !q_q.ack;
	assign wadr = i_wb_adr[ADR_MSB:ADR_LSB];

	always_comb begin
		wr_old = 32'h0000_0000;
		rd_val = 32'h0000_0000;
		if (wadr == ADR_ZERO_SPEED_LEVEL) begin
			rd_val = {25'h0, q_q.zsl};
		end else if (wadr == ADR_MIN_OUTPUT_FREQ) begin
			rd_val = {16'h0, q_q.minf};
		end else if (wadr == ADR_HOLD_GAIN) begin
			rd_val = {25'h0, q_q.gain};
		end else if (wadr == ADR_HOLD_WIDTH) begin
			rd_val = {18'h0, q_q.width};
		end else if (wadr == ADR_SPEED_REF) begin
			rd_val = {16'h0, q_q.speed_ref};
		end else if (wadr == ADR_STATUS) begin
			rd_val[ST_HOLD] = (q_q.st == HOLD_LOCKED);
			rd_val[ST_DONE] = q_q.hold_done;
			rd_val[ST_ENABLED] = hold_enabled;
			rd_val[ST_RUN] = run_on;
			rd_val[ST_CMD] = hold_cmd;
		end else if (wadr == ADR_POSITION) begin
			rd_val = position;
		end else if (wadr == ADR_CAPTURED) begin
			rd_val = q_q.cap;
		end else if (wadr == ADR_DEVIATION) begin
			rd_val = deviation;
		end else if (in_sel_hit(wadr)) begin
			rd_val = {24'h0, q_q.in_sel[4'(wadr - ADR_IN_SEL_BASE)]};
		end else if (out_sel_hit(wadr)) begin
			rd_val = {24'h0, q_q.out_sel[2'(wadr - ADR_OUT_SEL_BASE)]};
		end
		if (!read_only(wadr)) begin
			wr_old = rd_val;
		end
	end

	assign wr_val = lane_merge(wr_old, i_wb_dat, i_wb_sel);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		q_d = q_q;
		q_d.pin_s1 = {i_run, i_mf_in};
		q_d.pin_s2 = q_q.pin_s1;

		// hold state machine
		unique case (q_q.st)
			HOLD_IDLE: begin
				if (hold_request && below_zero_speed) begin
					q_d.st = HOLD_LOCKED;
					q_d.cap = position;
				end
			end
			HOLD_LOCKED: begin
				// speed reference no longer looked at while locked
				if (!hold_request) begin
					q_d.st = HOLD_IDLE;
				end
			end
		endcase

		// position loop correction, saturated
		if (q_d.st == HOLD_LOCKED && locked) begin
			q_d.corr = sat_corr(corr_full);
		end else begin
			q_d.corr = '0;
		end

		// completion window
		q_d.hold_done = (q_d.st == HOLD_LOCKED) && locked && hold_cmd && in_window;
		q_d.mf_out = done_sel_mask & {N_OUTPUTS{q_d.hold_done}};

		// wishbone: one wait state, ack for one cycle
		q_d.ack = wb_req;
		q_d.dat = wb_req ? rd_val : 32'h0000_0000;
		if (wb_req && i_wb_we) begin
			if (wadr == ADR_ZERO_SPEED_LEVEL) begin
				q_d.zsl = 7'(clamp_max(wr_val, ZSL_MAX));
			end else if (wadr == ADR_MIN_OUTPUT_FREQ) begin
				q_d.minf = wr_val[15:0];
			end else if (wadr == ADR_HOLD_GAIN) begin
				q_d.gain = 7'(clamp_max(wr_val, GAIN_MAX));
			end else if (wadr == ADR_HOLD_WIDTH) begin
				q_d.width = 14'(clamp_max(wr_val, WIDTH_MAX));
			end else if (wadr == ADR_SPEED_REF) begin
				q_d.speed_ref = wr_val[15:0];
			end else if (in_sel_hit(wadr)) begin
				q_d.in_sel[4'(wadr - ADR_IN_SEL_BASE)] = wr_val[7:0];
			end else if (out_sel_hit(wadr)) begin
				q_d.out_sel[2'(wadr - ADR_OUT_SEL_BASE)] = wr_val[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			q_q <= '0;
			q_q.st <= HOLD_IDLE;
			q_q.zsl <= ZSL_RST;
			q_q.minf <= MINF_RST;
			q_q.gain <= GAIN_RST;
			q_q.width <= WIDTH_RST;
		end else if (i_ce) begin
			q_q <= q_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_wb_dat = q_q.dat;
	assign o_wb_ack = q_q.ack;
	assign o_mf_out = q_q.mf_out;
	assign o_hold_active = (q_q.st == HOLD_LOCKED);
	assign o_hold_done = q_q.hold_done;
	assign o_speed_corr = q_q.corr;

endmodule

/* verif/zero_speed_position_hold_props.sv */
// checker: bus and hold-output relations of the zero-speed hold
`timescale 1ns/1ps
module zero_speed_position_hold_props
	import zero_hold_pkg::*;
(
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// wishbone
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// pins and results
	input wire logic [N_INPUTS-1:0] i_mf_in,
	input wire logic i_run,
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	input wire logic [N_OUTPUTS-1:0] o_mf_out,
	input wire logic o_hold_active,
	input wire logic o_hold_done,
	input wire logic signed [CORR_W-1:0] o_speed_corr
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset || !i_ce);
	////////////////////////////////////////////////////////////////////////////////
	chk_ack_one: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	chk_ack_next: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
		else $error("ack not one cycle after request");
	chk_dat_quiet: assert property (!o_wb_ack |-> o_wb_dat == '0)
		else $error("read data outside ack cycle");
	chk_entry_lag: assert property ($rose(o_hold_active) |-> $past(i_run, 3) && $past(i_mf_in, 3) != '0)
		else $error("hold entered without synced command and run");
	chk_done_held: assert property ($rose(o_hold_done) |-> o_hold_active && $past(o_hold_active))
		else $error("completion without a held cycle");
	chk_corr_idle: assert property (!o_hold_active [*3] |-> o_speed_corr == '0)
		else $error("correction outside hold");
	chk_out_route: assert property (o_mf_out != '0 |-> o_hold_done)
		else $error("output set without completion");
	chk_cmd_drop: assert property ((i_mf_in == '0) [*4] |-> !o_hold_done)
		else $error("completion kept after command drop");
	chk_run_drop: assert property ((!i_run) [*4] |-> !o_hold_active)
		else $error("hold kept without run");
	cover property ($rose(o_hold_active));
	cover property ($rose(o_hold_done));
	cover property ($fell(o_hold_done) && o_hold_active);
endmodule
bind zero_speed_position_hold zero_speed_position_hold_props chk (.*);

/* verif/shaft_enc_model.sv */
// shaft encoder model: quadrature phases stepped from a signed count
`timescale 1ns/1ps
module shaft_enc_model (
	// clock
	input wire logic i_sys_clk,
	// phases
	output logic o_a,
	output logic o_b
);
	int pos = 0;
	initial begin
		o_a = 1'b0;
		o_b = 1'b0;
	end
	// one edge per four clocks, a leads b counting up
	task automatic step(input int n);
		for (int i = 0; i < (n < 0 ? -n : n); i++) begin
			repeat (4) @(posedge i_sys_clk);
			pos += (n < 0) ? -1 : 1;
			o_a <= pos[1] ^ pos[0];
			o_b <= pos[1];
		end
	endtask
endmodule

/* verif/zero_speed_position_hold_tb.sv */
// testbench: settings, hold entry, completion window and correction
`timescale 1ns/1ps
module zero_speed_position_hold_tb;
	import zero_hold_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, odat;
	logic [N_INPUTS-1:0] mf = '0;
	logic [N_OUTPUTS-1:0] mfo;
	logic ack, hact, hdone, ea, eb;
	logic signed [CORR_W-1:0] corr;
	int mismatches = 0, n_checks = 0, cycles = 0, gain, width, cap;
	int steps[$];
	zero_speed_position_hold dut (.i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
		.i_wb_dat(wdat), .o_wb_dat(odat), .o_wb_ack(ack), .i_mf_in(mf), .i_run(run),
		.i_enc_a(ea), .i_enc_b(eb), .o_mf_out(mfo), .o_hold_active(hact),
		.o_hold_done(hdone), .o_speed_corr(corr));
	shaft_enc_model enc (.i_sys_clk(clk), .o_a(ea), .o_b(eb));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = odat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	// model of hold outputs from captured and current position
	task automatic hold_chk(input logic act);
		int dev, c, n;
		logic ed;
		dev = enc.pos - cap;
		c = -dev * gain;
		if (c > 32767) c = 32767;
		if (c < -32768) c = -32768;
		if (!act) c = 0;
		ed = act && dev <= width && dev >= -width;
		n = 0;
		while ((hact !== act || hdone !== ed || corr !== 16'(c)) && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, hact}, {31'h0, act});
		chk({31'h0, hdone}, {31'h0, ed});
		chk({16'h0, corr}, {16'h0, 16'(c)});
		chk({29'h0, mfo}, {29'h0, 1'b0, ed, 1'b0});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(96859));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h00, 32'h5);
		rd_chk(8'h08, 32'h5);
		rd_chk(8'h0c, 32'ha);
		rd_chk(8'hfc, 32'h0);
		wb(1'b1, 8'h00, 32'hff);
		rd_chk(8'h00, 32'h64);
		wb(1'b1, 8'h08, 32'hff);
		rd_chk(8'h08, 32'h64);
		wb(1'b1, 8'h0c, 32'hffff);
		rd_chk(8'h0c, 32'h3fff);
		gain = $urandom_range(100, 1);
		width = $urandom_range(30, 1);
		wb(1'b1, 8'h00, 32'h5);
		wb(1'b1, 8'h04, 32'h14);
		wb(1'b1, 8'h08, 32'(gain));
		wb(1'b1, 8'h0c, 32'(width));
		wb(1'b1, 8'h10, 32'h19);
		wb(1'b1, 8'h84, 32'h21);
		mf <= 10'h008;
		run <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0, hact}, 32'h0);
		wb(1'b1, 8'h4c, 32'h48);
		repeat (8) @(posedge clk);
		chk({31'h0, hact}, 32'h0);
		cap = enc.pos;
		wb(1'b1, 8'h10, 32'hfff1);
		hold_chk(1'b1);
		rd_chk(8'h14, 32'h1f);
		steps = '{width, 1, -2 * width - 1, -1};
		foreach (steps[i]) begin
			enc.step(steps[i]);
			hold_chk(1'b1);
		end
		wb(1'b1, 8'h10, 32'h64);
		hold_chk(1'b1);
		gain = 100;
		wb(1'b1, 8'h08, 32'h64);
		enc.step(500);
		hold_chk(1'b1);
		mf <= '0;
		hold_chk(1'b0);
		report_and_stop();
	end
endmodule
